// *** arc_fifo.sv ***
// Byte FIFO with valid/ready on both sides
`timescale 1ns/1ns
module arc_fifo
	import arc_pkg::*;
#(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic             i_core_clk,
	input  wire logic             i_sys_rst,
	// Fill side
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// Drain side
	output logic                  o_out_valid,
	output logic [WIDTH-1:0]      o_out_data,
	input  wire logic             i_out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_cfg
		$error("arc_fifo: DEPTH must be a power of two >= 2");
	end

	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
	} arc_fptr_type;

	logic [WIDTH-1:0] mem_q [DEPTH];
	arc_fptr_type     s_q;
	arc_fptr_type     s_d;
	logic             full;
	logic             empty;
	logic             push;
	logic             pop;

	assign full        = (s_q.wp[AW] != s_q.rp[AW]) && (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]);
	assign empty       = (s_q.wp == s_q.rp);
	assign o_in_ready  = !full;
	assign o_out_valid = !empty;
	assign push        = i_in_valid && !full;
	assign pop         = i_out_ready && !empty;
	assign o_out_data  = mem_q[s_q.rp[AW-1:0]];

	always_comb begin
		s_d = s_q;
		if (push)
			s_d.wp = s_q.wp + 1'b1;
		if (pop)
			s_d.rp = s_q.rp + 1'b1;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst)
			s_q <= '0;
		else
			s_q <= s_d;
		if (push)
			mem_q[s_q.wp[AW-1:0]] <= i_in_data;
	end
endmodule

// *** arc_host.sv ***
// Host model: sends query frames, collects reply bytes
`timescale 1ns/1ns
module arc_host
	import arc_pkg::*;
(
	// Clock
	input  wire logic       i_core_clk,
	// Query characters
	output logic            o_rx_valid,
	output logic [7:0]      o_rx_data,
	input  wire logic       i_rx_ready,
	// Reply characters
	input  wire logic       i_tx_valid,
	input  wire logic [7:0] i_tx_data,
	output logic            o_tx_ready,
	input  wire logic       i_stall
);
	logic [7:0] got_q[$];
	logic       timed_out;
	initial begin
		o_rx_valid = 1'b0;
		o_rx_data = 8'hFF;
		timed_out = 1'b0;
	end
	assign o_tx_ready = !i_stall;
	always @(posedge i_core_clk) begin
		if (i_tx_valid && o_tx_ready) got_q.push_back(i_tx_data);
	end
	// Hold each character until taken or 200 cycles pass; valid stays up between characters
	task automatic send(input logic [7:0] ch);
		int n;
		logic rdy;
		o_rx_valid = 1'b1;
		o_rx_data = ch;
		rdy = 1'b0;
		for (n = 0; n < 200 && !rdy; n++) begin
			@(negedge i_core_clk);
			rdy = i_rx_ready;
			@(posedge i_core_clk);
		end
		if (!rdy)
			timed_out = 1'b1;
		#1;
	endtask
	task automatic send_frame(input logic [7:0] t);
		send(t);
		send(CH_ZERO);
		send(CH_QUERY);
		send(CH_NL);
		send(CH_NUL);
		o_rx_valid = 1'b0;
		o_rx_data = ~CH_NUL;
	endtask
endmodule

// *** arc_pkg.sv ***
// Package for the ASCII read command responder
package arc_pkg;
	localparam logic [7:0] CH_NL     = 8'h0A;
	localparam logic [7:0] CH_NUL    = 8'h00;
	localparam logic [7:0] CH_QUERY  = 8'h3F;
	localparam logic [7:0] CH_COLON  = 8'h3A;
	localparam logic [7:0] CH_EQUAL  = 8'h3D;
	localparam logic [7:0] CH_ZERO   = 8'h30;
	localparam logic [7:0] CH_A_UP   = 8'h41;
	localparam logic [7:0] CH_LET_A  = 8'h41;
	localparam logic [7:0] CH_LET_Z  = 8'h5A;
	localparam logic [7:0] CH_DIG_9  = 8'h39;
	localparam logic [7:0] TYPE_DELAY = 8'h44;
	localparam logic [7:0] TYPE_GAIN  = 8'h47;
	localparam logic [7:0] TYPE_SER   = 8'h53;
	localparam logic [7:0] TYPE_HWG   = 8'h58;
	localparam logic [3:0] HEX_TEN    = 4'hA;
	localparam logic [4:0] REPLY_LEN  = 5'h12;
	localparam logic [4:0] POS_SEP1   = 5'h02;
	localparam logic [4:0] POS_CNT    = 5'h03;
	localparam logic [4:0] POS_EQ     = 5'h07;
	localparam logic [4:0] POS_VAL    = 5'h08;
	localparam logic [4:0] POS_NL     = 5'h10;
	localparam logic [15:0] CNT_MAX   = 16'hFFFF;
	localparam logic [15:0] CNT_ONE   = 16'h0001;
	localparam logic [9:0]  DELAY_RST = 10'h000;
	localparam logic [7:0]  GAIN_RST  = 8'h00;
	localparam int unsigned FIFO_DEPTH = 16;

	typedef enum logic [3:0] {
		ST_TYPE  = 4'b0001,
		ST_NUM   = 4'b0010,
		ST_IND   = 4'b0100,
		ST_SEND  = 4'b1000
	} arc_state_type;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} arc_byte_type;

	typedef struct packed {
		logic [9:0] delay;
		logic [7:0] gain;
	} arc_cfg_type;

	typedef struct packed {
		arc_state_type state;
		logic [7:0]    ftype;
		logic [7:0]    fnum;
		logic [31:0]   value;
		logic [15:0]   count;
		logic [4:0]    pos;
		logic [1:0]    hw_gain;
		arc_cfg_type   cfg;
	} arc_regs_type;
endpackage

// *** arc_responder.sv ***
// ASCII read query decoder and reply frame generator
`timescale 1ns/1ns

module arc_responder
	import arc_pkg::*;
#(
	parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0000,
	parameter int unsigned TX_DEPTH      = FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_sys_rst,
	// Received characters
	input  wire logic       i_rx_valid,
	input  wire logic [7:0] i_rx_data,
	output logic            o_rx_ready,
	// Configuration loaded by the write path
	input  wire logic       i_cfg_load,
	input  wire logic [9:0] i_cfg_delay,
	input  wire logic [7:0] i_cfg_gain,
	// Hardware gain lines
	input  wire logic       i_hw_gain_a,
	input  wire logic       i_hw_gain_b,
	// Reply characters
	output logic            o_tx_valid,
	output logic [7:0]      o_tx_data,
	input  wire logic       i_tx_ready,
	// Current configuration
	output logic [9:0]      o_delay,
	output logic [7:0]      o_gain,
	output logic [1:0]      o_hw_gain
);
	if (TX_DEPTH < 2) begin : g_bad_depth
		$error("arc_responder: TX_DEPTH too small");
	end

	arc_regs_type s_q;
	arc_regs_type s_d;
	arc_byte_type tx_b;
	logic         fifo_ready;
	logic [7:0]   rxc;
	logic         rx_take;
	logic [3:0]   nib;
	logic         known;

	function automatic logic [7:0] hex_char(input logic [3:0] n);
		hex_char = (n < HEX_TEN) ? (CH_ZERO + {4'h0, n}) : (CH_A_UP + {4'h0, n} - {4'h0, HEX_TEN});
	endfunction

	assign rxc        = i_rx_data;
	assign o_rx_ready = (s_q.state != ST_SEND);
	assign rx_take    = i_rx_valid && o_rx_ready;
	assign known      = (s_q.ftype == TYPE_DELAY) || (s_q.ftype == TYPE_GAIN) ||
	                    (s_q.ftype == TYPE_SER) || (s_q.ftype == TYPE_HWG);

	// Character to send at the current position
	always_comb begin
		nib       = 4'h0;
		tx_b.data = CH_NUL;
		if (s_q.pos < POS_SEP1)
			tx_b.data = (s_q.pos == 5'h00) ? s_q.ftype : s_q.fnum;
		else if (s_q.pos == POS_SEP1)
			tx_b.data = CH_COLON;
		else if (s_q.pos < POS_EQ) begin
			nib = s_q.count[4'(4'(3) - 4'(s_q.pos - POS_CNT)) * 4 +: 4];
			tx_b.data = hex_char(nib);
		end else if (s_q.pos == POS_EQ)
			tx_b.data = CH_EQUAL;
		else if (s_q.pos < POS_NL) begin
			nib = s_q.value[5'(5'(7) - 5'(s_q.pos - POS_VAL)) * 4 +: 4];
			tx_b.data = hex_char(nib);
		end else if (s_q.pos == POS_NL)
			tx_b.data = CH_NL;
		else
			tx_b.data = CH_NUL;
		tx_b.valid = (s_q.state == ST_SEND);
	end

	always_comb begin
		s_d         = s_q;
		s_d.hw_gain = {i_hw_gain_b, i_hw_gain_a};
		if (i_cfg_load) begin
			s_d.cfg.delay = i_cfg_delay;
			s_d.cfg.gain  = i_cfg_gain;
		end
		unique case (s_q.state)
			ST_TYPE: begin
				if (rx_take && rxc >= CH_LET_A && rxc <= CH_LET_Z) begin
					s_d.ftype = rxc;
					s_d.state = ST_NUM;
				end
			end
			ST_NUM: begin
				if (rx_take) begin
					if (rxc >= CH_ZERO && rxc <= CH_DIG_9) begin
						s_d.fnum  = rxc;
						s_d.state = ST_IND;
					end else
						s_d.state = ST_TYPE;
				end
			end
			ST_IND: begin
				if (rx_take) begin
					s_d.state = ST_TYPE;
					if (rxc == CH_QUERY && known) begin
						s_d.pos   = '0;
						s_d.state = ST_SEND;
						s_d.count = (s_q.count == CNT_MAX) ? '0 : s_q.count + CNT_ONE;
						unique case (s_q.ftype)
							TYPE_DELAY: s_d.value = {22'h0, s_q.cfg.delay};
							TYPE_GAIN:  s_d.value = {24'h0, s_q.cfg.gain};
							TYPE_SER:   s_d.value = SERIAL_NUMBER;
							default:    s_d.value = {30'h0, s_q.hw_gain};
						endcase
					end
				end
			end
			ST_SEND: begin
				if (fifo_ready) begin
					if (s_q.pos == REPLY_LEN - 5'h01)
						s_d.state = ST_TYPE;
					else
						s_d.pos = s_q.pos + 5'h01;
				end
			end
			default: s_d.state = ST_TYPE;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			s_q           <= '0;
			s_q.state     <= ST_TYPE;
			s_q.cfg.delay <= DELAY_RST;
			s_q.cfg.gain  <= GAIN_RST;
		end else
			s_q <= s_d;
	end

	arc_fifo #(
		.WIDTH (8),
		.DEPTH (TX_DEPTH)
	) u_tx_fifo (
		.i_core_clk  (i_core_clk),
		.i_sys_rst   (i_sys_rst),
		.i_in_valid  (tx_b.valid),
		.i_in_data   (tx_b.data),
		.o_in_ready  (fifo_ready),
		.o_out_valid (o_tx_valid),
		.o_out_data  (o_tx_data),
		.i_out_ready (i_tx_ready)
	);

	assign o_delay   = s_q.cfg.delay;
	assign o_gain    = s_q.cfg.gain;
	assign o_hw_gain = s_q.hw_gain;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);

	sequence q_accept;
		s_q.state == ST_IND && rx_take && rxc == CH_QUERY && known;
	endsequence

	a_count_step: assert property (q_accept |=> s_q.count == $past(s_q.count) + CNT_ONE)
		else $error("counter did not step by one");
	a_no_unknown: assert property (s_q.state == ST_IND && rx_take && !known |=> s_q.state == ST_TYPE)
		else $error("reply started for unknown type");
	a_delay_val: assert property ((q_accept and (s_q.ftype == TYPE_DELAY)) |=>
		s_q.value == {22'h0, $past(s_q.cfg.delay)})
		else $error("delay value wrong");
	a_gain_val: assert property ((q_accept and (s_q.ftype == TYPE_GAIN)) |=>
		s_q.value[7:0] == $past(s_q.cfg.gain))
		else $error("gain value wrong");
	a_serial_val: assert property ((q_accept and (s_q.ftype == TYPE_SER)) |=>
		s_q.value == SERIAL_NUMBER)
		else $error("serial value wrong");
	a_hw_gain: assert property (##1 s_q.hw_gain == {$past(i_hw_gain_b), $past(i_hw_gain_a)})
		else $error("hardware gain sample wrong");
	a_cfg_kept: assert property (!i_cfg_load |=> $stable(s_q.cfg))
		else $error("configuration changed by query");
	a_frame_sep: assert property (s_q.state == ST_SEND && s_q.pos == POS_EQ |-> tx_b.data == CH_EQUAL)
		else $error("equals separator misplaced");
	a_frame_end: assert property (s_q.state == ST_SEND && s_q.pos == POS_NL && fifo_ready |=>
		tx_b.data == CH_NUL && s_q.pos == REPLY_LEN - 5'h01)
		else $error("terminator wrong");
endmodule

// *** ascii_read_command_responder_tb.sv ***
// Self-checking testbench for the ASCII read command responder
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module ascii_read_command_responder_tb
	import arc_pkg::*;
;
	// Serial number value is arbitrary
	localparam logic [31:0] SER = 32'hC3A5_0F96;
	logic clk, rst, cfg_load, hw_a, hw_b, stall, rx_valid, rx_ready, tx_valid, tx_ready;
	logic [9:0] cfg_delay, delay;
	logic [7:0] cfg_gain, gain, rx_data, tx_data;
	logic [1:0] hwg;
	logic [15:0] cnt;
	int fail_count = 0;
	int num_checks = 0;
	always #5 clk = ~clk;
	arc_responder #(.SERIAL_NUMBER(SER)) dut_u (.i_core_clk(clk), .i_sys_rst(rst),
		.i_rx_valid(rx_valid), .i_rx_data(rx_data), .o_rx_ready(rx_ready),
		.i_cfg_load(cfg_load), .i_cfg_delay(cfg_delay), .i_cfg_gain(cfg_gain),
		.i_hw_gain_a(hw_a), .i_hw_gain_b(hw_b), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
		.i_tx_ready(tx_ready), .o_delay(delay), .o_gain(gain), .o_hw_gain(hwg));
	arc_host host_u (.i_core_clk(clk), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
		.i_rx_ready(rx_ready), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
		.o_tx_ready(tx_ready), .i_stall(stall));
	task automatic finish_test();
		`CHK("rx_timeout", 1'b0, host_u.timed_out)
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	function automatic logic [7:0] hexc(input logic [3:0] v);
		return (v < HEX_TEN) ? CH_ZERO + 8'(v) : CH_A_UP + 8'(v - HEX_TEN);
	endfunction
	// Wait for one whole reply and compare it byte by byte
	task automatic expect_reply(input logic [7:0] t, input logic [31:0] v);
		logic [7:0] e[18];
		logic [7:0] b;
		int n;
		cnt = cnt + 16'h0001;
		e[0] = t;
		e[1] = CH_ZERO;
		e[2] = CH_COLON;
		e[7] = CH_EQUAL;
		e[16] = CH_NL;
		e[17] = CH_NUL;
		for (n = 0; n < 4; n++) e[3+n] = hexc(cnt[15-4*n -: 4]);
		for (n = 0; n < 8; n++) e[8+n] = hexc(v[31-4*n -: 4]);
		for (n = 0; n < 600 && host_u.got_q.size() < 18; n++) begin
			@(posedge clk);
			#1;
		end
		if (host_u.got_q.size() < 18) begin
			fail_count++;
			$display("unexpected reply_len exp 18 got %0d", host_u.got_q.size());
			finish_test();
		end else begin
			for (n = 0; n < 18; n++) begin
				b = host_u.got_q.pop_front();
				`CHK("reply_byte", e[n], b)
			end
		end
	endtask
	task automatic t_delay();
		cfg_load = 1'b1;
		cfg_delay = 10'h3FF;
		cfg_gain = 8'hA5;
		@(posedge clk);
		#1 cfg_load = 1'b0;
		host_u.send_frame(TYPE_DELAY);
		expect_reply(TYPE_DELAY, 32'h0000_03FF);
		`CHK("delay", 10'h3FF, delay)
		`CHK("gain", 8'hA5, gain)
		$display("test delay done");
	endtask
	task automatic t_gain();
		stall = 1'b1;
		fork
			host_u.send_frame(TYPE_GAIN);
			begin
				repeat (60) @(posedge clk);
				#1;
				`CHK("stalled_bytes", 0, host_u.got_q.size())
				`CHK("tx_valid", 1'b1, tx_valid)
				`CHK("rx_ready", 1'b0, rx_ready)
				stall = 1'b0;
			end
		join
		expect_reply(TYPE_GAIN, 32'h0000_00A5);
		$display("test gain done");
	endtask
	task automatic t_serial();
		host_u.send_frame(TYPE_SER);
		expect_reply(TYPE_SER, SER);
		$display("test serial done");
	endtask
	task automatic t_hw(input logic a, input logic b);
		hw_a = a;
		hw_b = b;
		repeat (3) @(posedge clk);
		#1;
		`CHK("hw_gain", {b, a}, hwg)
		host_u.send_frame(TYPE_HWG);
		expect_reply(TYPE_HWG, {30'h0, b, a});
		$display("test hw gain done");
	endtask
	task automatic t_unknown();
		host_u.send_frame(8'h51);
		repeat (40) @(posedge clk);
		#1;
		`CHK("unknown_reply", 0, host_u.got_q.size())
		host_u.send_frame(TYPE_DELAY);
		expect_reply(TYPE_DELAY, 32'h0000_03FF);
		$display("test unknown done");
	endtask
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		cfg_load = 1'b0;
		cfg_delay = 10'h000;
		cfg_gain = 8'h00;
		hw_a = 1'b0;
		hw_b = 1'b0;
		stall = 1'b0;
		cnt = 16'h0000;
		repeat (3) @(posedge clk);
		#1 rst = 1'b0;
		`CHK("delay_rst", DELAY_RST, delay)
		`CHK("gain_rst", GAIN_RST, gain)
		`CHK("tx_valid_rst", 1'b0, tx_valid)
		t_delay();
		t_gain();
		t_serial();
		t_hw(1'b1, 1'b0);
		t_hw(1'b0, 1'b1);
		t_unknown();
		finish_test();
	end
endmodule
